// ===== hdl/conv_ctrl.sv
/*
 * Sync, single-shot, reset and standby control of a sigma-delta converter,
 * with mode, status, data and calibration registers on Avalon-MM.
 * Assumes all pins synchronous to i_clk; i_clk is the master clock.
 */
`timescale 1ns/1ps
module conv_ctrl
    import conv_ctrl_pkg::*;
#(
    parameter int DATA_W = 24
)
(
    // clock and reset
    input wire logic i_clk,
    input wire logic i_rst,
    // avalon-mm slave
    input wire avalon_req_t i_av,
    output avalon_rsp_t o_av,
    // control pins
    input wire logic i_restart_n,
    input wire logic i_reset_n,
    input wire logic i_standby_n,
    // modulator bitstream from the analog front end
    input wire logic i_mod_bit,
    // outputs
    output logic o_clk_out_en,
    output logic o_ready_n,
    output logic o_mod_run
);
    typedef struct packed {
        operating_mode_code_t operating_mode_code;
        operating_mode_code_t saved_mode;
        conv_state_t conv;
        logic [4:0] div;
        logic [7:0] count;
        logic [DATA_W-1:0] accum;
        logic [DATA_W-1:0] data;
        logic [DATA_W-1:0] offset_cal;
        logic ready_n;
        logic settled_flag_n;
        logic standby_flag;
        logic single;
        logic mod_run;
        logic clk_out_en;
        logic [31:0] readdata;
        logic waitrequest;
    } ctrl_state_t;

    ctrl_state_t state;
    ctrl_state_t next_state;

    logic restart_level;
    logic restart_rise;
    logic restart_fall;
    logic reset_level;
    logic standby_level;
    logic standby_rise;
    logic standby_fall;

    conv_edge_sampler #(.RESET_LEVEL(1'b1)) u_restart (
        .i_clk(i_clk),
        .i_rst(i_rst),
        .i_pin(i_restart_n),
        .o_level(restart_level),
        .o_rise(restart_rise),
        .o_fall(restart_fall)
    );

    conv_edge_sampler #(.RESET_LEVEL(1'b1)) u_reset (
        .i_clk(i_clk),
        .i_rst(i_rst),
        .i_pin(i_reset_n),
        .o_level(reset_level),
        .o_rise(),
        .o_fall()
    );

    conv_edge_sampler #(.RESET_LEVEL(1'b1)) u_standby (
        .i_clk(i_clk),
        .i_rst(i_rst),
        .i_pin(i_standby_n),
        .o_level(standby_level),
        .o_rise(standby_rise),
        .o_fall(standby_fall)
    );

    logic in_standby;
    logic mod_tick;
    logic acc_req;
    logic wr_mode;
    operating_mode_code_t wr_code;

    assign in_standby = ~standby_level | (state.operating_mode_code == MODE_STANDBY);
    assign mod_tick = (state.div == MOD_DIV_LAST);
    assign acc_req = (i_av.read | i_av.write) & state.waitrequest;
    assign wr_mode = acc_req & i_av.write & (i_av.address == OFF_MODE);
    assign wr_code = operating_mode_code_t'(i_av.writedata[MODE_LSB +: MODE_W]);

    function automatic ctrl_state_t reset_value();
        ctrl_state_t r;
        r = '0;
        r.operating_mode_code = MODE_CONT;
        r.saved_mode = MODE_CONT;
        r.conv = CONV_RUN;
        r.data = DATA_RESET[DATA_W-1:0];
        r.offset_cal = OFFSET_CAL_RESET[DATA_W-1:0];
        r.ready_n = 1'b1;
        r.settled_flag_n = 1'b1;
        r.clk_out_en = 1'b1;
        r.waitrequest = 1'b1;
        return r;
    endfunction : reset_value

    // start a settling run from a clean filter
    function automatic ctrl_state_t start_run(input ctrl_state_t s, input conv_state_t c);
        ctrl_state_t r;
        r = s;
        r.conv = c;
        r.count = '0;
        r.accum = '0;
        r.div = '0;
        return r;
    endfunction : start_run

    always_comb
    begin
        next_state = state;
        next_state.waitrequest = 1'b1;
        // modulator rate is master clock over 32
        next_state.div = 5'(state.div + 5'h01);
        // clock output always enabled, also in reset and standby
        next_state.clk_out_en = 1'b1;

        // avalon slave: one wait state, then answer
        if (acc_req)
        begin
            next_state.waitrequest = 1'b0;
            next_state.readdata = '0;
            if (i_av.read)
            begin
                unique case (i_av.address)
                    OFF_MODE: next_state.readdata[MODE_LSB +: MODE_W] = state.operating_mode_code;
                    OFF_STATUS:
                    begin
                        next_state.readdata[ST_READY_N] = state.ready_n;
                        next_state.readdata[ST_STANDBY] = state.standby_flag;
                        next_state.readdata[ST_SETTLED_N] = state.settled_flag_n;
                        next_state.readdata[ST_BUSY] = (state.conv != CONV_IDLE);
                    end
                    OFF_DATA: next_state.readdata[DATA_W-1:0] = state.data;
                    OFF_OFFSET_CAL: next_state.readdata[DATA_W-1:0] = state.offset_cal;
                    default: next_state.readdata = '0;
                endcase
            end
            else if (i_av.address == OFF_OFFSET_CAL)
            begin
                next_state.offset_cal = i_av.writedata[DATA_W-1:0];
            end
        end

        if (wr_mode)
        begin
            next_state.operating_mode_code = wr_code;
            unique case (wr_code)
                MODE_IDLE: next_state.conv = CONV_IDLE;
                MODE_CONT:
                begin
                    // result of the previous run is stale once a new run starts
                    next_state = start_run(next_state, CONV_RUN);
                    next_state.ready_n = 1'b1;
                end
                MODE_SINGLE:
                begin
                    next_state = start_run(next_state, CONV_RUN);
                    next_state.single = 1'b1;
                    next_state.ready_n = 1'b1;
                end
                MODE_STANDBY: next_state.conv = state.conv;
                default:
                begin
                    next_state = start_run(next_state, CONV_CAL);
                    next_state.ready_n = 1'b1;
                end
            endcase
        end

        // modulator and filter progress
        if (state.conv != CONV_IDLE && state.conv != CONV_HALT && !in_standby && mod_tick)
        begin
            next_state.count = 8'(state.count + 8'h01);
            if (state.conv == CONV_RUN)
            begin
                next_state.accum = DATA_W'(state.accum + DATA_W'(i_mod_bit));
                if (state.count == SETTLE_MOD_CYCLES)
                begin
                    next_state.data = state.accum;
                    next_state.ready_n = 1'b0;
                    next_state.settled_flag_n = 1'b0;
                    next_state.count = '0;
                    next_state.accum = '0;
                    if (state.single)
                    begin
                        // back to idle after the conversion
                        next_state.single = 1'b0;
                        next_state.conv = CONV_IDLE;
                        next_state.operating_mode_code = MODE_IDLE;
                    end
                end
            end
            else if (state.count == CAL_MOD_CYCLES)
            begin
                next_state.conv = CONV_IDLE;
                next_state.operating_mode_code = MODE_IDLE;
                next_state.ready_n = 1'b0;
                next_state.settled_flag_n = 1'b0;
            end
        end

        // restart low holds filter only, setup kept
        if (restart_fall || !restart_level)
        begin
            if (state.conv != CONV_IDLE)
            begin
                next_state.saved_mode = state.operating_mode_code;
                next_state = start_run(next_state, CONV_HALT);
            end
        end
        // release on rise, sampling from next edge
        else if (restart_rise)
        begin
            if (state.conv == CONV_HALT || state.operating_mode_code == MODE_IDLE)
            begin
                next_state = start_run(next_state, CONV_RUN);
                next_state.single = (state.operating_mode_code == MODE_IDLE) || state.single;
                next_state.ready_n = 1'b1;
            end
        end

        // standby forces ready and settled high
        if (in_standby)
        begin
            next_state.standby_flag = 1'b1;
            next_state.ready_n = 1'b1;
            next_state.settled_flag_n = 1'b1;
        end
        else
        begin
            // flags stay high until a new result
            next_state.standby_flag = 1'b0;
        end

        // standby holds filter progress; on pin release the divider restarts and operation resumes
        if (standby_rise)
        begin
            next_state.div = '0;
        end
        if (standby_fall)
        begin
            next_state.saved_mode = state.operating_mode_code;
        end

        next_state.mod_run = (next_state.conv == CONV_RUN || next_state.conv == CONV_CAL) && !next_state.standby_flag;

        // reset pin clears all, answers accesses with zero read data and drops writes; ready high
        if (!reset_level)
        begin
            next_state = reset_value();
            next_state.conv = CONV_HALT;
            next_state.waitrequest = ~acc_req;
            next_state.readdata = '0;
        end
        else if (state.conv == CONV_HALT && state.operating_mode_code == MODE_CONT && restart_level)
        begin
            // start converting with defaults after reset release
            next_state = start_run(next_state, CONV_RUN);
        end
    end

    always_ff @(posedge i_clk)
    begin
        if (i_rst)
        begin
            state <= reset_value();
        end
        else
        begin
            state <= next_state;
        end
    end

    assign o_av.readdata = state.readdata;
    assign o_av.waitrequest = state.waitrequest;
    assign o_ready_n = state.ready_n;
    assign o_mod_run = state.mod_run;
    assign o_clk_out_en = state.clk_out_en;
endmodule : conv_ctrl

// ===== hdl/conv_edge_sampler.sv
/*
 * Registers one control pin and reports its rising and falling edges.
 * Assumes the pin is already synchronous to i_clk.
 */
`timescale 1ns/1ps
module conv_edge_sampler
    import conv_ctrl_pkg::*;
#(
    parameter logic RESET_LEVEL = 1'b1
)
(
    // clock and reset
    input wire logic i_clk,
    input wire logic i_rst,
    // pin
    input wire logic i_pin,
    // edges
    output logic o_level,
    output logic o_rise,
    output logic o_fall
);
    typedef struct packed {
        logic level;
        logic rise;
        logic fall;
    } edge_state_t;

    edge_state_t state;
    edge_state_t next_state;

    always_comb
    begin
        next_state.level = i_pin;
        next_state.rise = i_pin & ~state.level;
        next_state.fall = ~i_pin & state.level;
    end

    always_ff @(posedge i_clk)
    begin
        if (i_rst)
        begin
            state <= '{level: RESET_LEVEL, rise: 1'b0, fall: 1'b0};
        end
        else
        begin
            state <= next_state;
        end
    end

    assign o_level = state.level;
    assign o_rise = state.rise;
    assign o_fall = state.fall;
endmodule : conv_edge_sampler

// ===== pkg/conv_ctrl_pkg.sv
/*
 * Shared constants and types of the converter control block: register
 * offsets, mode codes, reset values, cycle counts, the conversion states and the bus structs.
 * Assumes a single 200 MHz clock with a synchronous active-high reset.
 */
package conv_ctrl_pkg;

    // avalon register offsets (byte addresses)
    localparam logic [3:0] OFF_MODE = 4'h0;
    localparam logic [3:0] OFF_STATUS = 4'h4;
    localparam logic [3:0] OFF_DATA = 4'h8;
    localparam logic [3:0] OFF_OFFSET_CAL = 4'hC;

    // mode field position and width inside the mode register
    localparam int MODE_LSB = 0;
    localparam int MODE_W = 3;

    // status register bit positions
    localparam int ST_READY_N = 0;
    localparam int ST_STANDBY = 1;
    localparam int ST_SETTLED_N = 2;
    localparam int ST_BUSY = 3;

    // operating mode codes
    typedef enum logic [2:0] {
        MODE_IDLE = 3'b000,
        MODE_CONT = 3'b001,
        MODE_SINGLE = 3'b010,
        MODE_STANDBY = 3'b011,
        MODE_INT_ZERO = 3'b100,
        MODE_INT_FULL = 3'b101,
        MODE_SYS_ZERO = 3'b110,
        MODE_SYS_FULL = 3'b111
    } operating_mode_code_t;

    // nominal reset values; offset calibration and data are loaded at reset, gain is unused
    localparam logic [23:0] OFFSET_CAL_RESET = 24'h800000;
    localparam logic [23:0] GAIN_CAL_RESET = 24'h5A0000;
    localparam logic [23:0] DATA_RESET = 24'h800000;

    // master clock divider giving the modulator rate
    localparam int MOD_DIV = 32;
    localparam logic [4:0] MOD_DIV_LAST = 5'(MOD_DIV - 1);

    // filter settling and calibration lengths in modulator cycles
    localparam logic [7:0] SETTLE_MOD_CYCLES = 8'h30;
    localparam logic [7:0] CAL_MOD_CYCLES = 8'h60;

    typedef enum logic [1:0] {
        CONV_IDLE = 2'b00,
        CONV_RUN = 2'b01,
        CONV_CAL = 2'b10,
        CONV_HALT = 2'b11
    } conv_state_t;

    // avalon request bundle
    typedef struct packed {
        logic [3:0] address;
        logic read;
        logic write;
        logic [31:0] writedata;
    } avalon_req_t;

    typedef struct packed {
        logic [31:0] readdata;
        logic waitrequest;
    } avalon_rsp_t;

endpackage : conv_ctrl_pkg

// ===== test/conv_ctrl_monitor.sv
/*
 * Port checker of conv_ctrl: bus answer timing, reset, standby, restart.
 * Assumes one clock i_clk and sync active-high i_rst; bound below.
 */
`timescale 1ns/1ps
module conv_ctrl_monitor
    import conv_ctrl_pkg::*;
#(
    parameter int DATA_W = 24
)
(
    // clock and reset
    input wire logic i_clk,
    input wire logic i_rst,
    // bus
    input wire avalon_req_t i_av,
    input wire avalon_rsp_t o_av,
    // pins
    input wire logic i_restart_n,
    input wire logic i_reset_n,
    input wire logic i_standby_n,
    input wire logic i_mod_bit,
    input wire logic o_clk_out_en,
    input wire logic o_ready_n,
    input wire logic o_mod_run
);
    default clocking @(posedge i_clk); endclocking
    default disable iff (i_rst);

    sequence s_taken;
        (i_av.read || i_av.write) && o_av.waitrequest;
    endsequence
    sequence s_restart_up;
        $rose(i_restart_n) && i_reset_n && i_standby_n;
    endsequence

    a_clk_out_on: assert property (o_clk_out_en)
        else $error("clock output dropped");
    a_wait_answer: assert property (s_taken |=> !o_av.waitrequest)
        else $error("no answer one cycle after request");
    a_wait_cause: assert property (!o_av.waitrequest |-> $past(i_av.read || i_av.write))
        else $error("answer without request");
    a_wait_short: assert property (!o_av.waitrequest |=> o_av.waitrequest)
        else $error("answer held too long");
    a_reset_ready: assert property (!i_reset_n [*3] |-> o_ready_n && !o_mod_run)
        else $error("ready or run active in reset");
    a_standby_flag_ready: assert property (!i_standby_n [*4] |-> o_ready_n)
        else $error("ready low in standby");
    a_standby_flag_stays: assert property ($rose(i_standby_n) |-> o_ready_n [*8])
        else $error("ready fell right after standby");
    a_restart_hold: assert property (!i_restart_n [*4] |-> !o_mod_run)
        else $error("modulator runs while restart low");
    a_restart_go: assert property (s_restart_up |-> ##[1:6] o_mod_run)
        else $error("no run after restart release");
    a_ready_cause: assert property ($fell(o_ready_n) |-> $past(o_mod_run))
        else $error("ready fell with no conversion");
endmodule : conv_ctrl_monitor

bind conv_ctrl conv_ctrl_monitor #(.DATA_W(DATA_W)) u_monitor (.i_clk, .i_rst, .i_av, .o_av,
    .i_restart_n, .i_reset_n, .i_standby_n, .i_mod_bit, .o_clk_out_en, .o_ready_n, .o_mod_run);

// ===== test/conv_host_model.sv
/*
 * Host side pin driver: registers the pin levels asked by the bench and
 * feeds a changing modulator bit. Assumes the bench clock.
 */
`timescale 1ns/1ps
module conv_host_model
(
    // clock and asked levels {restart_n, reset_n, standby_n}
    input wire logic i_clk,
    input wire logic [2:0] i_pins,
    // driven pins
    output logic o_restart_n,
    output logic o_reset_n,
    output logic o_standby_n,
    output logic o_mod_bit
);
    logic [4:0] pat;

    initial
    begin
        {o_restart_n, o_reset_n, o_standby_n, o_mod_bit} = 4'hE;
        pat = 5'h15;
    end

    always @(posedge i_clk)
    begin
        {o_restart_n, o_reset_n, o_standby_n} <= i_pins;
        pat <= {pat[3:0], pat[4] ^ pat[2]};
        o_mod_bit <= pat[0];
    end
endmodule : conv_host_model

// ===== test/testbench.sv
/*
 * Self-checking bench of conv_ctrl with a host pin model.
 * Assumes 200 MHz clock and the package timing of settle and calibration.
 */
`timescale 1ns/1ps
module testbench;
    import conv_ctrl_pkg::*;
    localparam int SET_LO = (int'(SETTLE_MOD_CYCLES) - 1) * MOD_DIV;
    localparam int SET_HI = (int'(SETTLE_MOD_CYCLES) + 2) * MOD_DIV + 8;
    localparam int CAL_LO = (int'(CAL_MOD_CYCLES) - 1) * MOD_DIV;
    localparam int CAL_HI = (int'(CAL_MOD_CYCLES) + 2) * MOD_DIV + 8;
    localparam logic [31:0] CAL_DEF = {8'h00, OFFSET_CAL_RESET};
    // scaled stand-in for the oscillator start-up time
    localparam int OSC_WAIT = 64;
    logic i_clk, i_rst, i_restart_n, i_reset_n, i_standby_n, i_mod_bit;
    logic o_clk_out_en, o_ready_n, o_mod_run;
    logic [2:0] pins;
    logic [31:0] d0;
    avalon_req_t i_av;
    avalon_rsp_t o_av;
    int error_cnt = 0;
    int num_checks = 0;

    conv_ctrl i_dut (.i_clk, .i_rst, .i_av, .o_av, .i_restart_n, .i_reset_n, .i_standby_n,
        .i_mod_bit, .o_clk_out_en, .o_ready_n, .o_mod_run);
    conv_host_model i_host (.i_clk, .i_pins(pins), .o_restart_n(i_restart_n),
        .o_reset_n(i_reset_n), .o_standby_n(i_standby_n), .o_mod_bit(i_mod_bit));

    initial
    begin
        i_clk = 1'b0;
        forever #2.5 i_clk = ~i_clk;
    end

    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        num_checks++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask : check

    task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d, output logic [31:0] q);
        int n;
        n = 0;
        @(posedge i_clk);
        i_av <= '{address: a, read: !wr, write: wr, writedata: d};
        do
        begin
            @(posedge i_clk);
            n++;
        end
        while (o_av.waitrequest !== 1'b0 && n < 64);
        q = o_av.readdata;
        i_av <= '0;
        check("bus answer", 32'h1, 32'(n < 64));
    endtask : bus

    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        logic [31:0] q;
        bus(1'b1, a, d, q);
    endtask : wr

    task automatic rd(input logic [3:0] a, input logic [31:0] m, input logic [31:0] e, input string w);
        logic [31:0] q;
        bus(1'b0, a, 32'h0, q);
        check(w, e, q & m);
    endtask : rd

    // counts cycles until ready falls
    task automatic settle(input int lo, input int hi, input string w);
        int n;
        n = 0;
        while (o_ready_n !== 1'b0 && n <= hi)
        begin
            @(posedge i_clk);
            n++;
        end
        check(w, 32'h1, 32'(n >= lo && n <= hi));
    endtask : settle

    task automatic set_pins(input logic [2:0] v, input int wait_n);
        @(posedge i_clk);
        pins <= v;
        repeat (wait_n) @(posedge i_clk);
    endtask : set_pins

    task automatic t_boot;
        rd(OFF_MODE, 32'hFFFFFFFF, 32'h1, "mode default");
        rd(OFF_OFFSET_CAL, 32'hFFFFFFFF, CAL_DEF, "offset cal default");
        rd(4'h2, 32'hFFFFFFFF, 32'h0, "unmapped read");
        check("clock out", 32'h1, 32'(o_clk_out_en));
        settle(SET_LO, SET_HI, "first result");
    endtask : t_boot

    task automatic t_cal;
        repeat (OSC_WAIT) @(posedge i_clk);
        wr(OFF_MODE, 32'h4);
        repeat (MOD_DIV) @(posedge i_clk);
        check("ready during cal", 32'h1, 32'(o_ready_n));
        settle(CAL_LO, CAL_HI, "cal time");
        rd(OFF_MODE, 32'h7, 32'h0, "mode after cal");
    endtask : t_cal

    task automatic t_single;
        wr(OFF_MODE, 32'h2);
        repeat (MOD_DIV) @(posedge i_clk);
        check("run single", 32'h1, 32'(o_mod_run));
        settle(SET_LO, SET_HI, "single time");
        rd(OFF_MODE, 32'h7, 32'h0, "mode after single");
        rd(OFF_DATA, 32'hFF000000, 32'h0, "data upper");
    endtask : t_single

    task automatic t_restart;
        wr(OFF_OFFSET_CAL, 32'h123456);
        wr(OFF_MODE, 32'h1);
        set_pins(3'b011, 6);
        check("run in restart", 32'h0, 32'(o_mod_run));
        set_pins(3'b111, 4);
        check("run after restart", 32'h1, 32'(o_mod_run));
        settle(SET_LO, SET_HI, "restart resume");
        wr(OFF_MODE, 32'h0);
        set_pins(3'b011, 6);
        set_pins(3'b111, 4);
        check("ready at shot start", 32'h1, 32'(o_ready_n));
        settle(SET_LO, SET_HI, "restart shot");
        rd(OFF_MODE, 32'h7, 32'h0, "mode after shot");
        rd(OFF_OFFSET_CAL, 32'hFFFFFFFF, 32'h123456, "setup kept");
    endtask : t_restart

    task automatic t_standby_flag_pin;
        wr(OFF_MODE, 32'h1);
        settle(SET_LO, SET_HI, "cont result");
        bus(1'b0, OFF_DATA, 32'h0, d0);
        set_pins(3'b110, 6);
        check("ready in standby", 32'h1, 32'(o_ready_n));
        rd(OFF_STATUS, 32'h7, 32'h7, "standby status");
        rd(OFF_DATA, 32'hFFFFFFFF, d0, "data kept");
        set_pins(3'b111, 8);
        check("ready after standby", 32'h1, 32'(o_ready_n));
        settle(SET_LO, SET_HI, "resume");
    endtask : t_standby_flag_pin

    task automatic t_standby_flag_mode;
        wr(OFF_MODE, 32'h3);
        repeat (4) @(posedge i_clk);
        rd(OFF_STATUS, 32'h7, 32'h7, "mode standby status");
        wr(OFF_MODE, 32'h0);
    endtask : t_standby_flag_mode

    task automatic t_reset_pin;
        set_pins(3'b101, 6);
        check("ready in reset", 32'h1, 32'(o_ready_n));
        check("clock in reset", 32'h1, 32'(o_clk_out_en));
        wr(OFF_OFFSET_CAL, 32'hAA);
        rd(OFF_OFFSET_CAL, 32'hFFFFFFFF, 32'h0, "read in reset");
        set_pins(3'b111, 0);
        settle(SET_LO, SET_HI, "after reset");
        rd(OFF_OFFSET_CAL, 32'hFFFFFFFF, CAL_DEF, "cal after reset");
        wr(OFF_MODE, 32'h0);
    endtask : t_reset_pin

    task automatic tally_and_finish;
        $display("checks %0d errors %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : tally_and_finish

    initial
    begin
        i_rst = 1'b1;
        i_av = '0;
        pins = 3'b111;
        repeat (20) @(posedge i_clk);
        i_rst <= 1'b0;
        t_boot();
        t_cal();
        t_single();
        t_restart();
        t_standby_flag_pin();
        t_standby_flag_mode();
        t_reset_pin();
        tally_and_finish();
    end

    // cut a hang short
    initial
    begin
        #200us;
        error_cnt++;
        tally_and_finish();
    end
endmodule : testbench
